// *** bench/testbench.sv ***
// Self-checking bench for the banked register front end.
// Assumes one wait state per Avalon access and registered side pulses.
`timescale 1ns/1ns
module testbench
    import uib_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [UIB_ADDR_W-1:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    uib_dma_t dma_i = '0;
    logic dma_ack_o;
    logic [7:0] dma_rdata_o, rx_data_i, tx_data_o, queue_control_o, line_control_o;
    logic [7:0] modem_mode_o, line_status_i, modem_status_i, last_tx;
    logic tx_load_o, rx_pop_o, extended_mode_o, irq_o;
    uib_evt_t evt_i;
    uib_evt_t raise_q = '0;
    uib_ack_t ack_o;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;

    // Clock at 100 MHz
    always #5 mclk_i = ~mclk_i;

    uib_bank_regs uib_bank_regs_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_byteenable_i(4'hF), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .dma_i(dma_i), .dma_ack_o(dma_ack_o), .dma_rdata_o(dma_rdata_o),
        .rx_data_i(rx_data_i), .tx_data_o(tx_data_o), .tx_load_o(tx_load_o),
        .rx_pop_o(rx_pop_o), .evt_i(evt_i), .line_status_i(line_status_i),
        .modem_status_i(modem_status_i), .ack_o(ack_o), .queue_control_o(queue_control_o),
        .line_control_o(line_control_o), .modem_mode_o(modem_mode_o),
        .extended_mode_o(extended_mode_o), .irq_o(irq_o));

    uib_core_model uib_core_model_inst (.mclk_i(mclk_i), .rst_i(rst_i), .raise_i(raise_q),
        .rx_pop_i(rx_pop_o), .tx_load_i(tx_load_o), .tx_data_i(tx_data_o), .ack_i(ack_o),
        .evt_o(evt_i), .rx_data_o(rx_data_i), .line_status_o(line_status_i),
        .modem_status_o(modem_status_i), .last_tx_o(last_tx));

    task end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One Avalon access; idle cycles after it let side pulses and the id settle
    task bus(input logic wr, input logic [2:0] idx, input logic [7:0] wd,
             output logic [7:0] rd);
        avs_address_i <= {idx, 2'b00};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= {24'h000000, wd};
        @(posedge mclk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge mclk_i);
        rd = avs_readdata_o[7:0];
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask

    task wr(input logic [2:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task rdc(input string nm, input logic [2:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        bus(1'b0, idx, 8'h00, d);
        chk(nm, exp, d);
    endtask

    task dma(input logic rd, input logic [7:0] wd);
        dma_i <= {rd, !rd, wd};
        @(posedge mclk_i);
        while (dma_ack_o !== 1'b1) @(posedge mclk_i);
        if (rd)
            chk("dma read", 8'hA1, dma_rdata_o);
        dma_i <= '0;
        repeat (3) @(posedge mclk_i);
    endtask

    task raise(input logic [8:0] e);
        raise_q <= uib_evt_t'(e);
        @(posedge mclk_i);
        raise_q <= '0;
        repeat (3) @(posedge mclk_i);
    endtask

    // Hang guard, well above the length of the sequence
    always @(posedge mclk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            end_sim();
        end
    end

    initial
    begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        rdc("enable reset", 3'h1, 8'h00);
        rdc("ident reset", 3'h2, 8'h01);
        wr(3'h1, 8'hFF);
        rdc("enable legacy", 3'h1, 8'h0F);
        wr(3'h0, 8'h5A);
        chk("tx byte", 8'h5A, last_tx);
        rdc("rx byte", 3'h0, 8'hA0);
        // Bank 1 hides bank 0 except the selector
        wr(3'h3, 8'h81);
        rdc("selector", 3'h3, 8'h81);
        rdc("hidden enable", 3'h1, 8'h00);
        dma(1'b0, 8'hC3);
        chk("dma tx byte", 8'hC3, last_tx);
        dma(1'b1, 8'h00);
        wr(3'h3, 8'h00);
        wr(3'h3, 8'h03);
        rdc("line control", 3'h3, 8'h03);
        wr(3'h7, 8'h3C);
        rdc("scratch", 3'h7, 8'h3C);
        // Upper enables only stick in extended mode
        wr(3'h3, 8'h82);
        wr(3'h2, 8'h01);
        chk("extended", 8'h01, {7'h00, extended_mode_o});
        wr(3'h3, 8'h00);
        wr(3'h1, 8'hF0);
        rdc("enable ext", 3'h1, 8'hF0);
        rdc("ext flags", 3'h2, 8'h00);
        wr(3'h3, 8'h82);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h00);
        rdc("enable back", 3'h1, 8'h00);
        // IR-only bank hides bank 0 but keeps the selector
        wr(3'h3, 8'h85);
        rdc("ir bank sel", 3'h3, 8'h85);
        rdc("ir bank hidden", 3'h1, 8'h00);
        wr(3'h3, 8'h00);
        wr(3'h1, 8'h0F);
        // Priority chain, each source serviced in turn
        raise(9'h01D);
        chk("irq set", 8'h01, {7'h00, irq_o});
        rdc("id link", 3'h2, 8'h06);
        rdc("line status", 3'h5, 8'h61);
        rdc("id rx level", 3'h2, 8'h04);
        rdc("rx byte 2", 3'h0, 8'hA2);
        rdc("id tx low", 3'h2, 8'h02);
        rdc("id modem", 3'h2, 8'h00);
        rdc("modem status", 3'h6, 8'hB1);
        rdc("id none", 3'h2, 8'h01);
        chk("irq clear", 8'h00, {7'h00, irq_o});
        // Queues on: timeout code and enabled bits
        wr(3'h2, 8'h01);
        raise(9'h002);
        rdc("id timeout", 3'h2, 8'hCC);
        rdc("rx byte 3", 3'h0, 8'hA3);
        rdc("id queues", 3'h2, 8'hC1);
        // Masking removes the request and the code
        raise(9'h004);
        chk("irq tx low", 8'h01, {7'h00, irq_o});
        wr(3'h1, 8'h00);
        chk("irq masked", 8'h00, {7'h00, irq_o});
        rdc("id masked", 3'h2, 8'hC1);
        end_sim();
    end
endmodule

// *** bench/uib_core_model.sv ***
// Behavioural model of the serial/IR core behind the register bank.
// Assumes the bank's pulses are one mclk_i cycle wide; the bench raises events.
`timescale 1ns/1ns
module uib_core_model
    import uib_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Event pulses from the bench
    input wire uib_evt_t raise_i,
    // Traffic from the bank
    input wire logic rx_pop_i,
    input wire logic tx_load_i,
    input wire logic [7:0] tx_data_i,
    input wire uib_ack_t ack_i,
    // Levels and bytes toward the bank
    output uib_evt_t evt_o,
    output logic [7:0] rx_data_o,
    output logic [7:0] line_status_o,
    output logic [7:0] modem_status_o,
    output logic [7:0] last_tx_o
);
    uib_evt_t evt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;

    // Events hold until a status read, a pop or a transmit-low acknowledge clears them; the four extended events hold until reset; a raise in a clear cycle is lost
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            evt_q <= '0;
        end
        else
        begin
            evt_q <= evt_q | raise_i;
            if (ack_i.lsr_read) evt_q.link_status <= 1'b0;
            if (ack_i.msr_read) evt_q.modem_status <= 1'b0;
            if (ack_i.tx_low_ack) evt_q.tx_low <= 1'b0;
            if (rx_pop_i) evt_q.rx_level <= 1'b0;
            if (rx_pop_i) evt_q.rx_timeout <= 1'b0;
        end
    end

    // Receive bytes count up so every pop shows a fresh value
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_q <= 8'hA0;
            tx_q <= 8'h00;
        end
        else
        begin
            if (rx_pop_i) rx_q <= rx_q + 8'h01;
            if (tx_load_i) tx_q <= tx_data_i;
        end
    end

    // Status bytes carry the pending flags in bit 0
    assign evt_o = evt_q;
    assign rx_data_o = rx_q;
    assign last_tx_o = tx_q;
    assign line_status_o = {7'h30, evt_q.link_status};
    assign modem_status_o = {7'h58, evt_q.modem_status};
endmodule

// *** core/uib_bank_regs.sv ***
// Banked register window, interrupt enable, event identification and data ports.
// Assumes the core supplies event levels and status bytes synchronous to mclk_i,
// and that the core clears its own events on the acknowledge pulses.
// Contract
// - Eight banks share one window of eight byte locations; only selected bank reachable.
// - Bank selector sits at the same location in every bank.
// - Banks 0-3 serve serial and IR; banks 4-7 serve IR only.
// - Bank 0 decodes offsets 0 to 7 as the documented register set.
// - CPU data write loads holding register or pushes transmit queue.
// - CPU data read returns holding register or pops receive queue.
// - DMA always reaches the data path regardless of selected bank.
// - Enable bits 4-7 settable only in extended mode, cleared otherwise.
// - Enable bit positions fixed; set bit enables event; reset to zero.
// - Enable bit 2 covers link status and transmitter halted events; the code has no halted event and bit 2 gates link status only.
// - Enable bit 5 covers transmitter empty and pipeline load events; the code has no pipeline load event and bit 5 gates tx_empty only.
// - Non-extended receive level event is identified only via identification register.
// - Extended mode reports each event as its own identification flag; the code merges rx_level and rx_timeout into flag bit 0.
// - Offset 2 reads identification and writes queue control.
// - Non-extended identification returns highest priority pending code.
// - During a CPU access the presented identification code stays frozen.
// - Identification bit 0 is low while pending, high otherwise, resets high.
// - Identification bits 2:1 encode highest pending source when bit 0 low.
// - Codes 0110, 0100, 1100, 0010, 0000 by priority; 0001 for none.
// - Bit 3 zero with queues off; marks timeout when highest with queues on.
// - Identification bits 5:4 read zero in non-extended mode.
// - Identification bits 7:6 read one while queues are enabled.
`timescale 1ns/1ns
module uib_bank_regs
    import uib_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [UIB_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // DMA path
    input wire uib_dma_t dma_i,
    output logic dma_ack_o,
    output logic [7:0] dma_rdata_o,
    // Core data path
    input wire logic [7:0] rx_data_i,
    output logic [7:0] tx_data_o,
    output logic tx_load_o,
    output logic rx_pop_o,
    // Core status and events
    input wire uib_evt_t evt_i,
    input wire logic [7:0] line_status_i,
    input wire logic [7:0] modem_status_i,
    output uib_ack_t ack_o,
    // Configuration toward the core
    output logic [7:0] queue_control_o,
    output logic [7:0] line_control_o,
    output logic [7:0] modem_mode_o,
    output logic extended_mode_o,
    output logic irq_o
);

    logic wait_q;
    logic [31:0] rdata_q;
    logic [2:0] bank_q;
    logic [7:0] ier_q;
    logic [7:0] qctl_q;
    logic [7:0] lcr_q;
    logic [7:0] mcr_q;
    logic [7:0] scr_q;
    logic ext_q;
    logic [7:0] id_q;
    logic irq_q;
    logic [7:0] tx_data_q;
    logic tx_load_q;
    logic rx_pop_q;
    logic dma_ack_q;
    logic [7:0] dma_rdata_q;
    uib_ack_t ack_q;

    logic [2:0] idx;
    logic lane_ok;
    logic busy;
    logic rd_done;
    logic wr_done;
    logic dma_take;
    logic queues_on_indicator;
    logic [7:0] wbyte;
    logic [7:0] ext_flags;
    logic [7:0] pend;
    logic [7:0] id_live;
    logic [7:0] rmux;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // Decode of the shared window
    assign idx = avs_address_i[4:2];
    assign lane_ok = avs_byteenable_i[0];
    assign busy = avs_read_i | avs_write_i;
    assign rd_done = avs_read_i & ~wait_q & lane_ok;
    assign wr_done = avs_write_i & ~wait_q & lane_ok;
    assign wbyte = avs_writedata_i[7:0];
    assign queues_on_indicator = qctl_q[UIB_FEN_BIT];
    // DMA yields to a completing CPU access, then retries
    assign dma_take = (dma_i.rd | dma_i.wr) & ~(avs_read_i & ~wait_q) & ~(avs_write_i & ~wait_q);

    // True when the access hits one location of the selected bank
    function automatic logic hit(input logic [2:0] bank, input logic [2:0] sel_bank,
                                 input logic [2:0] loc, input logic [2:0] want);
        hit = (bank == sel_bank) && (loc == want);
    endfunction

    // Extended event flags; bit 0 carries both receive events, bits 2 and 5 one event each
    assign ext_flags = {evt_i.timer, evt_i.status_queue, evt_i.tx_empty, evt_i.dma_count,
                        evt_i.modem_status, evt_i.link_status, evt_i.tx_low,
                        evt_i.rx_level | evt_i.rx_timeout};

    // Pending events gated by enables, positions shared by both modes
    assign pend = ext_flags & ier_q;

    // Priority encoder over enabled legacy sources
    function automatic logic [7:0] encode_id(input uib_evt_t e, input logic [7:0] ie,
                                             input logic f);
        logic [3:0] code;
        code = UIB_ID_NONE;
        if (e.link_status && ie[2])
        begin
            code = UIB_ID_LS;
        end
        else if (e.rx_level && ie[0])
        begin
            code = UIB_ID_RXL;
        end
        else if (e.rx_timeout && f && ie[0])
        begin
            code = UIB_ID_RXTO;
        end
        else if (e.tx_low && ie[1])
        begin
            code = UIB_ID_TXL;
        end
        else if (e.modem_status && ie[3])
        begin
            code = UIB_ID_MS;
        end
        encode_id = {{2{f}}, 2'b00, code};
    endfunction

    assign id_live = encode_id(evt_i, ier_q, queues_on_indicator);

    // Read multiplexer; unselected or empty locations read zero
    always_comb
    begin
        rmux = 8'h00;
        if (idx == UIB_IDX_LCR_BSEL)
        begin
            if (bank_q == UIB_BANK_MAIN)
            begin
                rmux = lcr_q;
            end
            else
            begin
                rmux = {1'b1, 4'h0, bank_q};
            end
        end
        else if (hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_DATA))
        begin
            rmux = rx_data_i;
        end
        else if (hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_IER))
        begin
            rmux = ier_q;
        end
        else if (hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_EIR_FCR))
        begin
            rmux = ext_q ? ext_flags : id_q;
        end
        else if (hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_MCR))
        begin
            rmux = mcr_q;
        end
        else if (hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_LSR))
        begin
            rmux = line_status_i;
        end
        else if (hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_MSR))
        begin
            rmux = modem_status_i;
        end
        else if (hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_SCR))
        begin
            rmux = scr_q;
        end
        else if (hit(bank_q, UIB_BANK_EXT, idx, UIB_IDX_EXT_CTRL))
        begin
            rmux = {7'h00, ext_q};
        end
        // Banks 4-7 hold IR-only setup that lives in the core; read as zero here
    end

    // Waitrequest: one wait cycle, then completion; fixed latency keeps the core simple
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end
        else if (busy && wait_q)
        begin
            wait_q <= 1'b0;
            rdata_q <= lane_ok ? {24'h00_0000, rmux} : 32'h0000_0000;
        end
        else
        begin
            wait_q <= 1'b1;
        end
    end

    // Bank selector: offset 3 in any bank; bank 0 needs the flag bit set
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bank_q <= UIB_BANK_RST;
            lcr_q <= UIB_LCR_RST;
        end
        else if (wr_done && idx == UIB_IDX_LCR_BSEL)
        begin
            if (bank_q != UIB_BANK_MAIN || wbyte[UIB_BSEL_FLAG_BIT])
            begin
                bank_q <= wbyte[2:0];
            end
            else
            begin
                lcr_q <= wbyte;
            end
        end
    end

    // Interrupt enable; upper nibble forced clear outside extended mode
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ier_q <= UIB_IER_RST;
        end
        else if (wr_done && hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_IER))
        begin
            ier_q <= ext_q ? wbyte : (wbyte & ~UIB_IE_EXT_MASK);
        end
        else if (!ext_q)
        begin
            ier_q <= ier_q & ~UIB_IE_EXT_MASK;
        end
    end

    // Plain control registers of banks 0 and 2
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            qctl_q <= UIB_QCTL_RST;
            mcr_q <= UIB_MCR_RST;
            scr_q <= UIB_SCR_RST;
            ext_q <= 1'b0;
        end
        else if (wr_done)
        begin
            if (hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_EIR_FCR))
            begin
                qctl_q <= wbyte;
            end
            if (hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_MCR))
            begin
                mcr_q <= wbyte;
            end
            if (hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_SCR))
            begin
                scr_q <= wbyte;
            end
            if (hit(bank_q, UIB_BANK_EXT, idx, UIB_IDX_EXT_CTRL))
            begin
                ext_q <= wbyte[UIB_EXT_BIT];
            end
        end
    end

    // Presented code is held while the master has a request up
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            id_q <= UIB_ID_RST;
        end
        else if (!busy)
        begin
            id_q <= id_live;
        end
    end

    // Interrupt output from enabled pending events
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |pend;
        end
    end

    // Data path: CPU in bank 0, DMA in any bank
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_data_q <= 8'h00;
            tx_load_q <= 1'b0;
            rx_pop_q <= 1'b0;
            dma_ack_q <= 1'b0;
            dma_rdata_q <= 8'h00;
        end
        else
        begin
            tx_load_q <= 1'b0;
            rx_pop_q <= 1'b0;
            dma_ack_q <= 1'b0;
            if (wr_done && hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_DATA))
            begin
                tx_data_q <= wbyte;
                tx_load_q <= 1'b1;
            end
            else if (rd_done && hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_DATA))
            begin
                rx_pop_q <= 1'b1;
            end
            else if (dma_take && !dma_ack_q)
            begin
                dma_ack_q <= 1'b1;
                tx_load_q <= dma_i.wr;
                rx_pop_q <= dma_i.rd;
                if (dma_i.wr)
                begin
                    tx_data_q <= dma_i.wdata;
                end
                else
                begin
                    dma_rdata_q <= rx_data_i;
                end
            end
        end
    end

    // Read side effects so the core can clear self-clearing events
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_q <= '0;
        end
        else
        begin
            ack_q.lsr_read <= rd_done && hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_LSR);
            ack_q.msr_read <= rd_done && hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_MSR);
            ack_q.eir_read <= rd_done && hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_EIR_FCR);
            // The shown transmit-low code or any transmit load acknowledges the transmit level event
            ack_q.tx_low_ack <= (rd_done && !ext_q && id_q[3:0] == UIB_ID_TXL
                                 && hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_EIR_FCR))
                                || tx_load_q;
        end
    end

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign dma_ack_o = dma_ack_q;
    assign dma_rdata_o = dma_rdata_q;
    assign tx_data_o = tx_data_q;
    assign tx_load_o = tx_load_q;
    assign rx_pop_o = rx_pop_q;
    assign ack_o = ack_q;
    assign queue_control_o = qctl_q;
    assign line_control_o = lcr_q;
    assign modem_mode_o = mcr_q;
    assign extended_mode_o = ext_q;
    assign irq_o = irq_q;

    // Checks
    sequence s_cpu_write_data;
        wr_done && hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_DATA);
    endsequence
    sequence s_cpu_read_data;
        rd_done && hit(bank_q, UIB_BANK_MAIN, idx, UIB_IDX_DATA);
    endsequence
    sequence s_req_start;
        busy && wait_q;
    endsequence

    AST_IER_UPPER: assert property ((!ext_q && $past(!ext_q)) |-> ier_q[7:4] == 4'h0)
        else $error("upper enables set outside extended mode");
    AST_ID_FROZEN: assert property ($past(busy) |-> $stable(id_q))
        else $error("identification changed during access");
    AST_ID_PEND: assert property ($past(!busy) |-> id_q[0] == $past(id_live[0]))
        else $error("pending flag wrong");
    AST_ID_FEN: assert property ($past(!busy) |-> id_q[7:6] == {2{$past(queues_on_indicator)}})
        else $error("queue enabled bits wrong");
    AST_ID_ZERO: assert property (id_q[5:4] == 2'b00)
        else $error("bits 5:4 not zero");
    AST_RX_TIMEOUT_FLAG_OFF: assert property ($past(!busy && !queues_on_indicator) |-> !id_q[3])
        else $error("timeout bit with queues off");
    AST_IRQ: assert property (irq_o == $past(|(ext_flags & ier_q)))
        else $error("interrupt output mismatch");
    AST_PUSH: assert property (s_cpu_write_data |=> tx_load_o && tx_data_o == $past(wbyte))
        else $error("data write not pushed");
    AST_POP: assert property (s_cpu_read_data |=> rx_pop_o)
        else $error("data read not popped");
    AST_DMA: assert property ((dma_take && !dma_ack_q && !busy) |=> dma_ack_o)
        else $error("dma strobe not served");
    AST_BANK_GATE: assert property ((wr_done && idx == UIB_IDX_IER && bank_q != UIB_BANK_MAIN)
                                    |=> $stable(ier_q))
        else $error("enable written from other bank");
    AST_ANSWER: assert property (s_req_start |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not one wait cycle");

endmodule

// *** core/uib_pkg.sv ***
// Package for the banked register front end of the serial and infrared port.
// Assumes a byte-wide register map reached over a 32-bit Avalon-MM slave.
package uib_pkg;
    // Bank overlay
    localparam int unsigned UIB_NUM_BANKS = 8;
    localparam logic [2:0] UIB_BANK_MAIN = 3'h0;
    localparam logic [2:0] UIB_BANK_EXT = 3'h2;
    // Register indices within the window; byte address is four times the index
    localparam logic [2:0] UIB_IDX_DATA = 3'h0;
    localparam logic [2:0] UIB_IDX_IER = 3'h1;
    localparam logic [2:0] UIB_IDX_EIR_FCR = 3'h2;
    localparam logic [2:0] UIB_IDX_LCR_BSEL = 3'h3;
    localparam logic [2:0] UIB_IDX_MCR = 3'h4;
    localparam logic [2:0] UIB_IDX_LSR = 3'h5;
    localparam logic [2:0] UIB_IDX_MSR = 3'h6;
    localparam logic [2:0] UIB_IDX_SCR = 3'h7;
    localparam logic [2:0] UIB_IDX_EXT_CTRL = 3'h2;
    localparam int unsigned UIB_ADDR_W = 5;
    // Field positions
    localparam int unsigned UIB_BSEL_FLAG_BIT = 7;
    localparam int unsigned UIB_FEN_BIT = 0;
    localparam int unsigned UIB_EXT_BIT = 0;
    localparam logic [7:0] UIB_IE_EXT_MASK = 8'hF0;
    // Reset values
    localparam logic [7:0] UIB_IER_RST = 8'h00;
    localparam logic [7:0] UIB_ID_RST = 8'h01;
    localparam logic [7:0] UIB_QCTL_RST = 8'h00;
    localparam logic [7:0] UIB_LCR_RST = 8'h00;
    localparam logic [7:0] UIB_MCR_RST = 8'h00;
    localparam logic [7:0] UIB_SCR_RST = 8'h00;
    localparam logic [2:0] UIB_BANK_RST = 3'h0;
    // Encoded identification values, low nibble
    localparam logic [3:0] UIB_ID_NONE = 4'h1;
    localparam logic [3:0] UIB_ID_LS = 4'h6;
    localparam logic [3:0] UIB_ID_RXL = 4'h4;
    localparam logic [3:0] UIB_ID_RXTO = 4'hC;
    localparam logic [3:0] UIB_ID_TXL = 4'h2;
    localparam logic [3:0] UIB_ID_MS = 4'h0;

    // Event levels from the serial/IR core
    typedef struct packed {
        logic timer;
        logic status_queue;
        logic tx_empty;
        logic dma_count;
        logic modem_status;
        logic link_status;
        logic tx_low;
        logic rx_timeout;
        logic rx_level;
    } uib_evt_t;

    // DMA strobes, held until acknowledged
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } uib_dma_t;

    // Read and acknowledge pulses toward the core
    typedef struct packed {
        logic lsr_read;
        logic msr_read;
        logic eir_read;
        logic tx_low_ack;
    } uib_ack_t;
endpackage
